/* File: hw/sew_eeprom.sv */
// serial eeprom two-wire addressing, write and program cycle logic
`timescale 1ns/100ps
// What this block does
// RULE_01: array is 128 pages of 16 bytes
// RULE_02: device address byte follows every start
// RULE_03: upper four bits must match type identifier
// RULE_04: address byte bits 3..1 are array bits 10..8
// RULE_05: bit 0 one reads, zero writes
// RULE_06: ack on match, not-ack on mismatch
// RULE_07: word address byte gives array bits 7..0
// RULE_08: host writes start, address, word, data
// RULE_09: ack three bytes; stop launches programming
// RULE_10: inputs ignored while programming runs
// RULE_11: page write takes up to 16 bytes
// RULE_12: host may send fifteen more data bytes
// RULE_13: only low four address bits increment
// RULE_14: in-page address wraps to page start
// RULE_15: no address ack during programming
// RULE_16: host polls with write address until ack
// RULE_17: no array access processed while programming
// RULE_18: write-protect high protects whole array
// RULE_19: protect sampled at stop, later ignored
// RULE_20: protected write acks, no programming cycle
// RULE_21: start and stop are data edges, clock high
// RULE_22: msb first, ack low on ninth clock
// RULE_23: mismatch returns idle until next start
// RULE_24: programming done returns to idle
// RULE_25: programming length is a build parameter
module sew_eeprom
  import sew_pkg::*;
#(
  parameter int unsigned PROG_LEN = PROG_CYCLES  // RULE_25
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic              wp_i,
  output logic                   prog_busy,
  output logic                   prog_we,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic [7:0]             prog_data,
  output logic                   read_sel
);

  // ******************************
  // input synchronisers
  // ******************************
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] wp_s_q;
  logic       scl_d1_q;
  logic       sda_d1_q;

  // two flops per pin; only the second flop is read
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q  <= 2'h0;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      wp_s_q  <= {wp_s_q[0], wp_i};
    end
  end

  // previous synchronised values for edge finding
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_d1_q <= 1'h1;
      sda_d1_q <= 1'h1;
    end else begin
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  logic    scl_s;
  logic    sda_s;
  sew_ev_t ev;

  assign scl_s = scl_s_q[1];
  assign sda_s = sda_s_q[1];

  // bus conditions; clock must be high before and after
  always_comb begin
    ev.start = scl_s & scl_d1_q & sda_d1_q & ~sda_s;  // RULE_21
    ev.stop  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;  // RULE_21
    ev.rise  = scl_s & ~scl_d1_q;
    ev.fall  = ~scl_s & scl_d1_q;
  end

  // ******************************
  // byte framing
  // ******************************
  sew_state_t  state_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        ack_hold_q;
  sew_state_t  after_ack_q;

  // the byte is complete on the eighth rising clock
  assign rx_byte   = {shift_q[6:0], sda_s};
  assign byte_done = ev.rise && (bit_q == 3'(LAST_BIT));

  // match of the type identifier
  function automatic logic dev_match(input logic [7:0] b,
                                     input logic [3:0] id);
    dev_match = (b[DEV_TYPE_MSB:DEV_TYPE_LSB] == id);
  endfunction

  localparam logic [3:0] DEV_TYPE_ID = 4'h5;  // arbitrary neutral value

  // ******************************
  // program cycle
  // ******************************
  logic [PCNT_W-1:0] pcnt_q;
  logic              busy_q;
  logic              prot_q;

  // ******************************
  // addressing and page buffer
  // ******************************
  logic [ROW_W-1:0] row_q;
  logic [OFS_W-1:0] ofs_q;
  logic [7:0]       page_q [PAGE_BYTES];  // RULE_01
  logic [PAGE_BYTES-1:0] dirty_q;
  logic             have_data_q;
  logic             wr_sel_q;
  logic [OFS_W:0]   flush_q;
  logic             flushing_q;

  // bit counter and shifter, msb first
  always_ff @(posedge mclk) begin
    if (rst || ev.start) begin
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
    end else if (ev.rise && state_q != ST_ACK) begin
      shift_q <= rx_byte;  // RULE_22
      bit_q   <= bit_q + 3'h1;
    end
  end

  // protocol state machine
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      after_ack_q <= ST_IDLE;
      ack_hold_q  <= 1'h0;
      wr_sel_q    <= 1'h0;
      read_sel    <= 1'h0;
    end else if (busy_q || flushing_q) begin
      // deaf while programming; polling is not-acked by silence
      state_q    <= ST_IDLE;  // RULE_10 RULE_15 RULE_17
      ack_hold_q <= 1'h0;
    end else if (ev.start) begin
      state_q    <= ST_DEVADR;  // RULE_02
      ack_hold_q <= 1'h0;
      wr_sel_q   <= 1'h0;
    end else if (ev.stop) begin
      state_q    <= ST_IDLE;
      ack_hold_q <= 1'h0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE: begin
          ack_hold_q <= 1'h0;
        end
        ST_DEVADR: begin
          if (byte_done) begin
            if (dev_match(rx_byte, DEV_TYPE_ID)) begin  // RULE_03
              state_q    <= ST_ACK;
              ack_hold_q <= 1'h1;  // RULE_06
              read_sel   <= rx_byte[DEV_RW_BIT];  // RULE_05
              wr_sel_q   <= ~rx_byte[DEV_RW_BIT];
              // reads are outside this block: go quiet after ack
              after_ack_q <= rx_byte[DEV_RW_BIT] ? ST_IGNORE
                                                 : ST_WORDADR;
            end else begin
              state_q <= ST_IGNORE;  // RULE_06 RULE_23
            end
          end
        end
        ST_WORDADR, ST_DATA: begin
          if (byte_done) begin
            state_q     <= ST_ACK;
            ack_hold_q  <= 1'h1;  // RULE_09 RULE_12 RULE_20
            after_ack_q <= ST_DATA;
          end
        end
        ST_ACK: begin
          // release after the falling edge ending the ninth clock
          if (ev.fall && !ack_hold_q) begin
            state_q <= after_ack_q;
          end
          if (ev.rise) begin
            ack_hold_q <= 1'h0;
          end
        end
      endcase
    end
  end

  // ack drive: pull low from fall after bit 8 until ninth clock ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_oe <= 1'h0;
    end else if (state_q == ST_ACK && ev.fall && ack_hold_q) begin
      sda_oe <= 1'h1;  // RULE_22
    end else if (state_q != ST_ACK || (ev.fall && !ack_hold_q)) begin
      sda_oe <= 1'h0;
    end
  end

  assign sda_o = 1'h0;  // open drain: only ever pulls low

  // address load and in-page increment
  always_ff @(posedge mclk) begin
    if (rst) begin
      row_q <= '0;
      ofs_q <= '0;
    end else if (!busy_q && !flushing_q) begin
      if (state_q == ST_DEVADR && byte_done) begin
        row_q[ROW_W-1 -: 3] <= rx_byte[DEV_HI_MSB:DEV_HI_LSB];  // RULE_04
      end else if (state_q == ST_WORDADR && byte_done) begin
        row_q[ROW_W-4:0] <= rx_byte[LAST_BIT:OFS_W];  // RULE_07
        ofs_q            <= rx_byte[OFS_W-1:0];  // RULE_07
      end else if (state_q == ST_DATA && byte_done) begin
        ofs_q <= ofs_q + 4'h1;  // RULE_13 RULE_14
      end
    end
  end

  // page buffer fill; a wrap overwrites earlier bytes of the page
  always_ff @(posedge mclk) begin
    if (rst) begin
      dirty_q     <= '0;
      have_data_q <= 1'h0;
    end else if (ev.start && !busy_q && !flushing_q) begin
      dirty_q     <= '0;
      have_data_q <= 1'h0;
    end else if (!busy_q && !flushing_q && state_q == ST_DATA
                 && byte_done) begin
      page_q[ofs_q]  <= rx_byte;  // RULE_11 RULE_14
      dirty_q[ofs_q] <= 1'h1;
      have_data_q    <= 1'h1;
    end else if (flushing_q && flush_q == 5'(PAGE_BYTES)) begin
      dirty_q     <= '0;
      have_data_q <= 1'h0;
    end
  end

  // protect sampled at the stop ending a write with data
  logic launch;
  assign launch = ev.stop && wr_sel_q && have_data_q
                  && !busy_q && !flushing_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prot_q <= 1'h0;
    end else if (launch) begin
      prot_q <= wp_s_q[1];  // RULE_19
    end
  end

  // hand bytes to the array one per cycle, then time the cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      flushing_q <= 1'h0;
      flush_q    <= '0;
    end else if (launch && !wp_s_q[1]) begin
      flushing_q <= 1'h1;  // RULE_18 RULE_20
      flush_q    <= '0;
    end else if (flushing_q) begin
      if (flush_q == 5'(PAGE_BYTES)) begin
        flushing_q <= 1'h0;
      end else begin
        flush_q <= flush_q + 5'h1;
      end
    end
  end

  // array write port, registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      prog_we   <= 1'h0;
      prog_addr <= '0;
      prog_data <= 8'h00;
    end else if (flushing_q && flush_q < 5'(PAGE_BYTES)
                 && dirty_q[flush_q[OFS_W-1:0]]) begin
      prog_we   <= 1'h1;  // RULE_11
      prog_addr <= {row_q, flush_q[OFS_W-1:0]};
      prog_data <= page_q[flush_q[OFS_W-1:0]];
    end else begin
      prog_we <= 1'h0;
    end
  end

  // self-timed cycle counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'h0;
      pcnt_q <= '0;
    end else if (flushing_q && flush_q == 5'(PAGE_BYTES)) begin
      busy_q <= 1'h1;  // RULE_09
      pcnt_q <= PCNT_W'(PROG_LEN);  // RULE_25
    end else if (busy_q) begin
      if (pcnt_q <= PCNT_W'(1)) begin
        busy_q <= 1'h0;  // RULE_24
      end else begin
        pcnt_q <= pcnt_q - PCNT_W'(1);
      end
    end
  end

  assign prog_busy = busy_q | flushing_q;

endmodule // sew_eeprom

/* File: hw/sew_pkg.sv */
// constants and carrier types for the serial eeprom write front end
package sew_pkg;

  // ******************************
  // array organisation
  // ******************************
  localparam int unsigned PAGE_COUNT = 128;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned OFS_W      = 4;
  localparam int unsigned ROW_W      = ADDR_W - OFS_W;

  // ******************************
  // device address byte layout
  // ******************************
  localparam int unsigned DEV_TYPE_MSB = 7;
  localparam int unsigned DEV_TYPE_LSB = 4;
  localparam int unsigned DEV_HI_MSB   = 3;
  localparam int unsigned DEV_HI_LSB   = 1;
  localparam int unsigned DEV_RW_BIT   = 0;
  localparam int unsigned LAST_BIT     = 7;

  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned PROG_US     = 5000;
  localparam int unsigned PROG_CYCLES = PROG_US * CLK_MHZ;
  localparam int unsigned PCNT_W      = 32;

  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } sew_wr_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } sew_ev_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADR,
    ST_WORDADR,
    ST_DATA,
    ST_ACK,
    ST_IGNORE
  } sew_state_t;

endpackage

/* File: tb/sew_asserts.sv */
// assertion checker for the eeprom write front end
`timescale 1ns/100ps
module sew_asserts
  import sew_pkg::*;
#(
  parameter int unsigned PROG_LEN = 50
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe,
  input wire logic              wp_i,
  input wire logic              prog_busy,
  input wire logic              prog_we,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [7:0]        prog_data,
  input wire logic              read_sel
);
  // ****************
  // helper logic
  // ****************
  logic [PCNT_W-1:0] bcnt_q;
  // busy run length, judged when busy drops
  always_ff @(posedge mclk) begin
    if (rst) begin
      bcnt_q <= '0;
    end else begin
      bcnt_q <= prog_busy ? bcnt_q + 1'b1 : '0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************
  // properties
  // ****************
  sequence s_quiet; !sda_oe [*8]; endsequence
  property p_rst_quiet; $fell(rst) |-> !sda_oe && !prog_busy && !prog_we;
  endproperty
  property p_sda_low; sda_o == 1'b0; endproperty
  property p_oe_rise; $rose(sda_oe) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  property p_oe_fall; $fell(sda_oe) |-> !scl_i; endproperty
  property p_we_busy; prog_we |-> prog_busy; endproperty
  property p_busy_quiet; $rose(prog_busy) |-> s_quiet; endproperty
  // same row, rising offset within one scan
  property p_row_hold; prog_we && $past(prog_we) |->
    (prog_addr >> OFS_W) == ($past(prog_addr) >> OFS_W)
    && prog_addr > $past(prog_addr); endproperty
  property p_busy_len; $fell(prog_busy) |-> bcnt_q >= PROG_LEN; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  a_sda_low: assert property (p_sda_low)
    else $error("data drive value not low");
  a_oe_rise: assert property (p_oe_rise)
    else $error("ack started while clock high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("ack ended while clock high");
  a_we_busy: assert property (p_we_busy)
    else $error("array write outside program cycle");
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("ack driven at start of program cycle");
  a_row_hold: assert property (p_row_hold)
    else $error("page scan left its row");
  a_busy_len: assert property (p_busy_len)
    else $error("program cycle too short");
endmodule // sew_asserts

bind sew_eeprom sew_asserts #(.PROG_LEN(PROG_LEN)) u_chk (.mclk(mclk),
  .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .wp_i(wp_i), .prog_busy(prog_busy), .prog_we(prog_we),
  .prog_addr(prog_addr), .prog_data(prog_data), .read_sel(read_sel));

/* File: tb/sew_host.sv */
// two-wire bus host model driving clock and data toward the eeprom
`timescale 1ns/100ps
module sew_host (
  input  wire logic mclk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_h
);
  // ****************
  // bus idle
  // ****************
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves mid-low, read late in the high phase
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_h <= b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sda_w;
    tick(1);
    scl <= 1'b0;
  endtask
  // msb first, ninth clock released for the ack
  task automatic byte_io(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic start();
    tick(2);
    sda_h <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_h <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_h <= 1'b1;
    tick(4);
  endtask
endmodule // sew_host

/* File: tb/tb_sew_eeprom.sv */
// self-checking bench for the eeprom write front end
`timescale 1ns/100ps
module tb_sew_eeprom;
  import sew_pkg::*;
  localparam logic [3:0] TYPE_ID = 4'h5; // arbitrary type code
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              wp_i = 1'b0;
  logic              scl, sda_h, sda_w, sda_o, sda_oe;
  logic              prog_busy, prog_we, read_sel;
  logic [ADDR_W-1:0] prog_addr;
  logic [7:0]        prog_data;
  logic [31:0]       seed = 32'hD8B8595F;
  int                miscompares = 0;
  int                checked = 0;
  int                cyc = 0;
  sew_wr_t           wq[$];
  // open drain wire with pull-up
  assign sda_w = sda_h & (sda_oe ? sda_o : 1'b1);
  sew_eeprom #(.PROG_LEN(50)) DUT (.mclk(mclk), .rst(rst), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i),
    .prog_busy(prog_busy), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .read_sel(read_sel));
  sew_host u_host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_h(sda_h));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write n random bytes; wp flips after stop
  task automatic wr(input logic [2:0] hi, input logic [7:0] wa,
                    input int n, input logic wp);
    logic [7:0]  val [16];
    logic [15:0] used;
    logic [3:0]  o;
    logic        a;
    used = '0;
    o = wa[3:0];
    wp_i <= wp;
    u_host.start();
    u_host.byte_io({TYPE_ID, hi, 1'b0}, a);
    check("dev ack", a, 1);
    u_host.byte_io(wa, a);
    check("word ack", a, 1);
    repeat (n) begin
      val[o] = 8'(rnd());
      used[o] = 1'b1;
      u_host.byte_io(val[o], a);
      check("data ack", a, 1);
      o++;
    end
    // scan order is ascending offset, last value wins
    for (int k = 0; k < 16; k++)
      if (!wp && used[k]) wq.push_back({hi, wa[7:4], 4'(k), val[k]});
    u_host.stop();
    wp_i <= !wp;
  endtask
  task automatic poll(input logic [7:0] b, input logic e);
    logic a;
    u_host.start();
    u_host.byte_io(b, a);
    check("poll ack", a, e);
    u_host.stop();
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 2000 && prog_busy !== 1'b0; k++) @(posedge mclk);
    check("idle", prog_busy, 0);
  endtask
  // ****************
  // result watcher and timeout
  // ****************
  // falling edge: registered array port has settled since the rising edge
  always @(negedge mclk) begin
    cyc++;
    if (prog_we === 1'b1) begin
      if (wq.size() == 0) check("extra write", 1, 0);
      else check("write", {prog_addr, prog_data}, wq.pop_front());
    end
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    wr(3'h7, 8'hFE, 4, 1'b0);
    check("busy", prog_busy, 1);
    poll({TYPE_ID, 3'h7, 1'b0}, 1'b0);
    wait_idle();
    poll({TYPE_ID, 3'h7, 1'b0}, 1'b1);
    wr(3'h2, 8'h30, 16, 1'b0);
    wait_idle();
    wr(3'h0, 8'h05, 1, 1'b1);
    check("busy", prog_busy, 0);
    poll({TYPE_ID, 3'h0, 1'b0}, 1'b1);
    poll(8'h3E, 1'b0);
    poll({TYPE_ID, 3'h1, 1'b1}, 1'b1);
    check("read sel", read_sel, 1);
    check("drained", wq.size(), 0);
    tally_and_finish();
  end
endmodule // tb_sew_eeprom
